// ### common/usb_engine_pkg.sv
`default_nettype none
package usb_engine_pkg;
    // i/o register offsets
    localparam logic [7:0] EP0_TRANSMIT_CONFIG_OFFSET = 8'h10;
    localparam logic [7:0] EP1_TRANSMIT_CONFIG_OFFSET = 8'h11;
    localparam logic [7:0] LINK_SC_OFFSET = 8'h13;
    localparam logic [7:0] EP0_RX_OFFSET = 8'h14;
    // every register clears to this
    localparam logic [7:0] REG_RESET = 8'h00;
    // transmit config fields; bit 4 is rx error on endpoint 0, enable on endpoint 1
    localparam int TX_IN_ARM_BIT = 7;
    localparam int TX_TOGGLE_BIT = 6;
    localparam int TX_STALL_BIT = 5;
    localparam int TX_RX_ERR_BIT = 4;
    localparam int TX_EP1_EN_BIT = 4;
    // status and control fields
    localparam int SC_OUT_EN_BIT = 4;
    localparam int SC_AUTO_STAT_BIT = 3;
    localparam int SC_DRIVE_J_BIT = 2;
    localparam int SC_DRIVE_K_BIT = 1;
    localparam int SC_BUS_ACT_BIT = 0;
    // endpoint 0 receive status fields
    localparam int RX_TOGGLE_BIT = 3;
    localparam int RX_IN_BIT = 2;
    localparam int RX_OUT_BIT = 1;
    localparam int RX_SETUP_BIT = 0;
    // payload limit and crc bytes added to the receive count
    localparam logic [3:0] MAX_PAYLOAD = 4'h8;
    localparam logic [3:0] CRC_BYTES = 4'h2;
    // token kinds from the packet layer
    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_t;
    // handshake kinds sent to the packet layer
    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} handshake_t;
endpackage
`default_nettype wire

// ### common/line_sense_if.sv
`timescale 1ns/100ps
`default_nettype none
// raw line levels in, activity level out
interface line_sense_if;
    logic dp_raw; // d+ straight from the pin
    logic dm_raw; // d- straight from the pin
    logic non_idle; // synchronised, line not idle
    modport monitor (input dp_raw, input dm_raw, output non_idle);
    modport engine (output dp_raw, output dm_raw, input non_idle);
endinterface
`default_nettype wire

// ### hdl/line_state_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module line_state_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // line levels and activity
    line_sense_if.monitor sense
);
    logic [1:0] dp_sync; // two-stage sync of d+
    logic [1:0] dm_sync; // two-stage sync of d-
    logic active; // registered non-idle level

    // synchronisers, reset to the idle levels
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            dp_sync <= 2'h0;
            dm_sync <= 2'h3;
        end else begin
            dp_sync <= {dp_sync[0], sense.dp_raw};
            dm_sync <= {dm_sync[0], sense.dm_raw};
        end
    end

    // idle is d+ low with d- high; anything else counts
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            active <= 1'b0;
        end else begin
            active <= dp_sync[1] | ~dm_sync[1];
        end
    end

    assign sense.non_idle = active;
endmodule // line_state_monitor
`default_nettype wire

// ### hdl/usb_endpoint_engine_control.sv
// Overview of operation
// - endpoint 1 in answer carries count bytes
// - endpoint 1 ignored unless enabled
// - endpoint 1 stall answers stall until cleared
// - endpoint 1 toggle select picks data0/data1
// - armed in sends data; ack disarms, interrupts
// - setup always stored; ack valid, silent error
// - out enable stores out; else nak
// - out enable cleared by setup, acked out
// - auto status: ack zero data1, stall rest
// - setup token clears auto status
// - non-idle line sets bus activity flag
// - write zero clears activity; one keeps
// - drive bits force k or j state
// - reset clears status and transmit registers
// - crc, pid, stuff or oversize is error
// - setup/out data error sets error bit
// - endpoint 0 stall; cleared by setup
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_engine_control (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // firmware i/o register port
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // decoded token from the packet layer
    input wire logic i_tok_valid,
    input wire usb_engine_pkg::token_t i_tok_type,
    input wire logic [3:0] i_tok_ep,
    // end of a received data packet
    input wire logic i_data_done,
    input wire logic i_data_err,
    input wire logic i_data_pid1,
    input wire logic [3:0] i_data_len,
    // host acknowledged our in data
    input wire logic i_in_ack,
    // handshake request
    output logic o_hs_valid,
    output usb_engine_pkg::handshake_t o_hs_code,
    // in data request
    output logic o_in_send,
    output logic o_in_ep1,
    output logic [3:0] o_in_count,
    output logic o_in_toggle,
    // endpoint 0 fifo commit and interrupts
    output logic o_fifo_commit,
    output logic o_ep0_int,
    output logic o_ep1_int,
    // line pins and forced states
    input wire logic i_usb_dp,
    input wire logic i_usb_dm,
    output logic o_drive_j,
    output logic o_drive_k
);
    logic [7:0] ep0_transmit_config; // endpoint 0 transmit config
    logic [7:0] ep1_transmit_config; // endpoint 1 transmit config
    logic [7:0] scr; // link status and control
    logic [7:0] ep0_rx; // endpoint 0 receive status
    usb_engine_pkg::token_t cur_tok; // token of the open transaction
    logic cur_ep1; // open transaction is for endpoint 1
    logic tok_live; // a token awaits its data packet
    logic in_wait; // in data sent, awaiting ack
    logic in_wait_ep1; // which endpoint that in was

    line_sense_if sense ();
    assign sense.dp_raw = i_usb_dp;
    assign sense.dm_raw = i_usb_dm;

    // activity detector behind a two-flop sync
    line_state_monitor u_mon (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .sense(sense)
    );

    // token decode
    wire tok_ep0 = i_tok_valid && (i_tok_ep == 4'h0);
    wire tok_ep1 = i_tok_valid && (i_tok_ep == 4'h1);
    wire setup_tok = tok_ep0 && (i_tok_type == usb_engine_pkg::TOK_SETUP);
    wire in0 = tok_ep0 && (i_tok_type == usb_engine_pkg::TOK_IN);
    wire in1 = tok_ep1 && (i_tok_type == usb_engine_pkg::TOK_IN);
    wire ep1_on = ep1_transmit_config[usb_engine_pkg::TX_EP1_EN_BIT];
    wire ep1_stall = ep1_transmit_config[usb_engine_pkg::TX_STALL_BIT];
    wire ep0_stall = ep0_transmit_config[usb_engine_pkg::TX_STALL_BIT];
    wire auto_stat = scr[usb_engine_pkg::SC_AUTO_STAT_BIT];
    wire out_on = scr[usb_engine_pkg::SC_OUT_EN_BIT];

    // in answers: stall first, then armed data, else nak
    wire in0_stall = in0 && ep0_stall;
    wire in0_send = in0 && !ep0_stall && ep0_transmit_config[usb_engine_pkg::TX_IN_ARM_BIT];
    wire in1_stall = in1 && ep1_on && ep1_stall;
    wire in1_send = in1 && ep1_on && !ep1_stall && ep1_transmit_config[usb_engine_pkg::TX_IN_ARM_BIT];
    wire in_nak = (in0 && !in0_stall && !in0_send) ||
        (in1 && ep1_on && !in1_stall && !in1_send);

    // data phase decode
    wire data_ev = i_data_done && tok_live;
    wire pkt_err = i_data_err || (i_data_len > usb_engine_pkg::MAX_PAYLOAD);
    wire is_setup = data_ev && !cur_ep1 && (cur_tok == usb_engine_pkg::TOK_SETUP);
    wire is_out = data_ev && !cur_ep1 && (cur_tok == usb_engine_pkg::TOK_OUT);
    wire out1_stall = data_ev && cur_ep1 && ep1_on && ep1_stall &&
        (cur_tok == usb_engine_pkg::TOK_OUT) && !pkt_err;
    wire out_stall = is_out && ep0_stall;
    wire out_stat = is_out && !ep0_stall && auto_stat;
    wire out_en = is_out && !ep0_stall && !auto_stat && out_on;
    wire out_nak = is_out && !ep0_stall && !auto_stat && !out_on && !pkt_err;
    wire status_ok = i_data_pid1 && (i_data_len == 4'h0);

    // table effects of the data phase
    wire fifo_wr = is_setup || out_en;
    wire upd_toggle = is_setup || out_stat || out_en;
    wire upd_count = is_setup || out_en || (out_stat && !pkt_err);
    wire err_set = (is_setup || is_out) && pkt_err;
    wire clr_out_on = setup_tok || (out_en && !pkt_err);
    wire ack_data = (is_setup || out_en || (out_stat && status_ok)) && !pkt_err;
    wire stall_data = ((out_stall || (out_stat && !status_ok)) && !pkt_err) || out1_stall;
    wire ack0 = i_in_ack && in_wait && !in_wait_ep1;
    wire ack1 = i_in_ack && in_wait && in_wait_ep1;

    // register writes, hardware updates applied on top
    wire wr0 = i_io_wr && (i_io_addr == usb_engine_pkg::EP0_TRANSMIT_CONFIG_OFFSET);
    wire wr1 = i_io_wr && (i_io_addr == usb_engine_pkg::EP1_TRANSMIT_CONFIG_OFFSET);
    wire wrs = i_io_wr && (i_io_addr == usb_engine_pkg::LINK_SC_OFFSET);
    wire wrr = i_io_wr && (i_io_addr == usb_engine_pkg::EP0_RX_OFFSET);
    wire [7:0] base0 = wr0 ? i_io_wdata : ep0_transmit_config;
    wire [7:0] base1 = wr1 ? i_io_wdata : ep1_transmit_config;
    wire [7:0] next_ep0_transmit_config = {base0[7] && !(setup_tok || ack0), base0[6],
        base0[5] && !setup_tok, base0[4] || err_set, base0[3:0]};
    wire [7:0] next_ep1_transmit_config = {base1[7] && !ack1, base1[6:0]};
    wire bus_activity_flag_keep = wrs ? (i_io_wdata[0] && scr[0]) : scr[0];
    wire [4:0] sc_base = wrs ? i_io_wdata[4:0] : scr[4:0];
    wire [7:0] next_scr = {3'h0, sc_base[4] && !clr_out_on, sc_base[3] && !setup_tok,
        sc_base[2:1], bus_activity_flag_keep || sense.non_idle};
    wire setup_hold = tok_live && (cur_tok == usb_engine_pkg::TOK_SETUP);
    wire [7:0] rx_base = wrr ? {4'h0, ep0_rx[3], 2'h0, ep0_rx[0] && setup_hold} : ep0_rx;
    wire [3:0] rx_count = upd_count ? 4'(i_data_len + usb_engine_pkg::CRC_BYTES) : rx_base[7:4];
    wire rx_toggle = upd_toggle ? i_data_pid1 : rx_base[3];
    wire rx_in = tok_ep0 ? (i_tok_type == usb_engine_pkg::TOK_IN) : rx_base[2];
    wire rx_out = tok_ep0 ? (i_tok_type == usb_engine_pkg::TOK_OUT) : rx_base[1];
    wire [7:0] next_ep0_rx = {rx_count, rx_toggle, rx_in, rx_out, rx_base[0] || setup_tok};

    // read mux, reserved and unmapped read zero
    wire [7:0] next_rdata =
        (i_io_addr == usb_engine_pkg::EP0_TRANSMIT_CONFIG_OFFSET) ? ep0_transmit_config :
        (i_io_addr == usb_engine_pkg::EP1_TRANSMIT_CONFIG_OFFSET) ? ep1_transmit_config :
        (i_io_addr == usb_engine_pkg::LINK_SC_OFFSET) ? scr :
        (i_io_addr == usb_engine_pkg::EP0_RX_OFFSET) ? ep0_rx : 8'h00;

    // register file
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ep0_transmit_config <= usb_engine_pkg::REG_RESET;
            ep1_transmit_config <= usb_engine_pkg::REG_RESET;
            scr <= usb_engine_pkg::REG_RESET;
            ep0_rx <= usb_engine_pkg::REG_RESET;
            o_io_rdata <= 8'h00;
        end else begin
            ep0_transmit_config <= next_ep0_transmit_config;
            ep1_transmit_config <= next_ep1_transmit_config;
            scr <= next_scr;
            ep0_rx <= next_ep0_rx;
            o_io_rdata <= next_rdata;
        end
    end

    // open transaction tracking; disabled endpoint 1 takes none
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cur_tok <= usb_engine_pkg::TOK_OUT;
            cur_ep1 <= 1'b0;
            tok_live <= 1'b0;
            in_wait <= 1'b0;
            in_wait_ep1 <= 1'b0;
        end else if (tok_ep0 || (tok_ep1 && ep1_on)) begin
            cur_tok <= i_tok_type;
            cur_ep1 <= tok_ep1;
            tok_live <= (i_tok_type != usb_engine_pkg::TOK_IN);
            in_wait <= in0_send || in1_send;
            in_wait_ep1 <= in1_send;
        end else begin
            tok_live <= tok_live && !i_data_done;
            in_wait <= in_wait && !i_in_ack;
        end
    end

    // answers to the packet layer, one cycle after the cause
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_hs_valid <= 1'b0;
            o_hs_code <= usb_engine_pkg::HS_NAK;
            o_in_send <= 1'b0;
            o_in_ep1 <= 1'b0;
            o_in_count <= 4'h0;
            o_in_toggle <= 1'b0;
            o_fifo_commit <= 1'b0;
            o_ep0_int <= 1'b0;
            o_ep1_int <= 1'b0;
        end else begin
            o_hs_valid <= ack_data || stall_data || out_nak || in_nak || in0_stall || in1_stall;
            o_hs_code <= ack_data ? usb_engine_pkg::HS_ACK :
                (stall_data || in0_stall || in1_stall) ? usb_engine_pkg::HS_STALL :
                usb_engine_pkg::HS_NAK;
            o_in_send <= in0_send || in1_send;
            o_in_ep1 <= in1_send;
            o_in_count <= in1_send ? ep1_transmit_config[3:0] : ep0_transmit_config[3:0];
            o_in_toggle <= in1_send ? ep1_transmit_config[usb_engine_pkg::TX_TOGGLE_BIT] :
                ep0_transmit_config[usb_engine_pkg::TX_TOGGLE_BIT];
            o_fifo_commit <= fifo_wr;
            o_ep0_int <= upd_count || ack0;
            o_ep1_int <= ack1;
        end
    end

    // forced line states for resume signalling
    assign o_drive_k = scr[usb_engine_pkg::SC_DRIVE_K_BIT];
    assign o_drive_j = scr[usb_engine_pkg::SC_DRIVE_J_BIT];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_armed_in1;
        in1_send ##1 o_in_send;
    endsequence
    a_ep1_gate_off: assert property (in1 && !ep1_on |=> !o_hs_valid && !o_in_send)
        else $error("disabled endpoint 1 answered");
    a_ep1_stall_ans: assert property (in1 && ep1_on && ep1_stall |=>
        o_hs_valid && o_hs_code == usb_engine_pkg::HS_STALL)
        else $error("endpoint 1 stall not sent");
    a_ep1_in_data: assert property (s_armed_in1 |-> o_in_ep1 &&
        o_in_toggle == $past(ep1_transmit_config[6]) && o_in_count == $past(ep1_transmit_config[3:0]))
        else $error("endpoint 1 data wrong count or toggle");
    a_ep1_ack_disarm: assert property (ack1 |=> !ep1_transmit_config[7] && o_ep1_int)
        else $error("endpoint 1 ack did not disarm");
    a_setup_clears: assert property (setup_tok |=> !scr[4] && !scr[3] && !ep0_transmit_config[5])
        else $error("setup left control bits set");
    a_setup_error: assert property (is_setup && pkt_err |=>
        !o_hs_valid && o_fifo_commit && ep0_transmit_config[4])
        else $error("erroneous setup handled wrongly");
    a_out_nak: assert property (out_nak |=> o_hs_valid &&
        o_hs_code == usb_engine_pkg::HS_NAK && !o_fifo_commit)
        else $error("unenabled out not naked");
    a_status_ack: assert property (out_stat && !pkt_err && status_ok |=>
        o_hs_code == usb_engine_pkg::HS_ACK && o_hs_valid && !o_fifo_commit)
        else $error("status out not acked");
    a_bus_act_set: assert property (sense.non_idle |=> scr[0] [*1])
        else $error("activity flag not set");
    a_bus_act_w1: assert property (wrs && i_io_wdata[0] && scr[0] |=> scr[0])
        else $error("writing one changed activity flag");
endmodule // usb_endpoint_engine_control
`default_nettype wire

// ### bench/usb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the link: tokens, data phases, acks and raw line levels
module usb_host_model (
    // clock
    input wire logic i_clk,
    // device answer watched by the host
    input wire logic i_in_send,
    // token and data phase toward the engine
    output var logic o_tok_valid,
    output var usb_engine_pkg::token_t o_tok_type,
    output var logic [3:0] o_tok_ep,
    output var logic o_data_done,
    output var logic o_data_err,
    output var logic o_data_pid1,
    output var logic [3:0] o_data_len,
    output var logic o_in_ack,
    // raw line levels, idle is d+ low and d- high
    output var logic o_usb_dp,
    output var logic o_usb_dm
);
    logic sent; // a data packet came back for our in token
    // quiet bus at time zero
    initial begin
        {o_tok_valid, o_data_done, o_in_ack, o_data_err, o_data_pid1} = 5'h00;
        o_tok_type = usb_engine_pkg::TOK_OUT;
        {o_tok_ep, o_data_len} = 8'hFF;
        {o_usb_dp, o_usb_dm} = 2'b01;
    end
    // one transaction: token, one idle cycle, then data phase or ack
    task automatic xfer(input usb_engine_pkg::token_t t, input logic [3:0] ep,
        input logic dat, input logic err, input logic pid1, input logic [3:0] len,
        input logic ack);
        @(posedge i_clk) #1;
        {o_tok_valid, o_tok_ep} = {1'b1, ep};
        o_tok_type = t;
        @(posedge i_clk) #1;
        {o_tok_valid, o_tok_ep} = {1'b0, ~ep}; // released fields do not hold
        sent = i_in_send; // only acknowledge data that really came
        @(posedge i_clk) #1;
        {o_data_done, o_data_err, o_data_pid1, o_data_len} = {dat, err, pid1, len};
        o_in_ack = ack & sent;
        @(posedge i_clk) #1;
        {o_data_done, o_in_ack} = 2'b00;
        {o_data_err, o_data_pid1, o_data_len} = ~{err, pid1, len};
        repeat (3) @(posedge i_clk);
    endtask
    // hold a line state for n cycles, then back to idle
    task automatic line(input logic dp, input logic dm, input int n);
        @(posedge i_clk) #1;
        {o_usb_dp, o_usb_dm} = {dp, dm};
        repeat (n) @(posedge i_clk);
        #1;
        {o_usb_dp, o_usb_dm} = 2'b01;
    endtask
endmodule // usb_host_model
`default_nettype wire

// ### bench/usb_endpoint_engine_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_engine_control_tb;
    localparam logic [7:0] E0 = usb_engine_pkg::EP0_TRANSMIT_CONFIG_OFFSET; // short offset names
    localparam logic [7:0] E1 = usb_engine_pkg::EP1_TRANSMIT_CONFIG_OFFSET;
    localparam logic [7:0] SC = usb_engine_pkg::LINK_SC_OFFSET;
    localparam usb_engine_pkg::token_t T_IN = usb_engine_pkg::TOK_IN;
    localparam usb_engine_pkg::token_t T_OUT = usb_engine_pkg::TOK_OUT;
    logic clk = 1'b0; // 100 MHz
    logic nrst = 1'b0; // sync reset, active low
    logic [7:0] addr = 8'h00; // register port
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic tok_valid, data_done, data_err, data_pid1, in_ack, dp, dm; // host side
    usb_engine_pkg::token_t tok_type;
    logic [3:0] tok_ep, data_len, in_count, len;
    logic hs_valid, in_send, in_ep1, in_toggle, commit, int0, int1, drive_j, drive_k;
    usb_engine_pkg::handshake_t hs_code;
    logic [7:0] ev = 8'h00; // seen: send b6, int1 b5, int0 b4, commit b3, code b2:1, hs b0
    logic [5:0] inf = 6'h00; // seen in data: ep1, toggle, count
    logic [7:0] seed = 8'h34; // lfsr state
    logic [7:0] r, x, e; // read back, draw, expectation
    logic [7:0] regs [4] = '{E0, E1, SC, 8'h15}; // three of the four mapped places (not 8'h14) plus an unmapped one
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // free running clock
    always #5 clk = ~clk;
    usb_endpoint_engine_control u_usb_endpoint_engine_control (.i_clk(clk), .i_nrst(nrst),
        .i_io_addr(addr), .i_io_wr(wr), .i_io_wdata(wdata), .o_io_rdata(rdata),
        .i_tok_valid(tok_valid), .i_tok_type(tok_type), .i_tok_ep(tok_ep),
        .i_data_done(data_done), .i_data_err(data_err), .i_data_pid1(data_pid1),
        .i_data_len(data_len), .i_in_ack(in_ack), .o_hs_valid(hs_valid), .o_hs_code(hs_code),
        .o_in_send(in_send), .o_in_ep1(in_ep1), .o_in_count(in_count),
        .o_in_toggle(in_toggle), .o_fifo_commit(commit), .o_ep0_int(int0), .o_ep1_int(int1),
        .i_usb_dp(dp), .i_usb_dm(dm), .o_drive_j(drive_j), .o_drive_k(drive_k));
    usb_host_model u_usb_host_model (.i_clk(clk), .i_in_send(in_send),
        .o_tok_valid(tok_valid), .o_tok_type(tok_type), .o_tok_ep(tok_ep),
        .o_data_done(data_done), .o_data_err(data_err), .o_data_pid1(data_pid1),
        .o_data_len(data_len), .o_in_ack(in_ack), .o_usb_dp(dp), .o_usb_dm(dm));
    // capture one-cycle answers at the edge that ends them; a token starts afresh
    always @(posedge clk) begin
        if (tok_valid) {ev, inf} <= 14'h0000;
        if (hs_valid) ev[2:0] <= {hs_code, 1'b1};
        if (commit) ev[3] <= 1'b1;
        if (int0) ev[4] <= 1'b1;
        if (int1) ev[5] <= 1'b1;
        if (in_send) {ev[6], inf} <= {1'b1, in_ep1, in_toggle, in_count};
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one register write, strobe high for one cycle
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {addr, wr, wdata} = {a, 1'b1, d};
        @(posedge clk) #1;
        wr = 1'b0;
    endtask
    // read data follows the address one cycle later
    task automatic rreg(input logic [7:0] a);
        @(posedge clk) #1;
        addr = a;
        @(posedge clk) #1;
        r = rdata;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected endpoint 0 out answer as {int0, commit, code, hs}; stall beats status beats enable
    function automatic logic [7:0] exp_out(input logic stall, input logic stat, input logic en,
        input logic err, input logic pid1, input logic [3:0] ln);
        logic bad, cm, i0;
        usb_engine_pkg::handshake_t c;
        bad = err || (ln > 4'h8);
        cm = !stall && !stat && en;
        i0 = !stall && (cm || (stat && !bad));
        c = stall ? usb_engine_pkg::HS_STALL : stat ? ((pid1 && ln == 4'h0) ?
            usb_engine_pkg::HS_ACK : usb_engine_pkg::HS_STALL) : en ? usb_engine_pkg::HS_ACK :
            usb_engine_pkg::HS_NAK;
        return {3'h0, i0, cm, bad ? usb_engine_pkg::HS_ACK : c, !bad};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        wreg(8'h15, 8'hFF); // unmapped write is dropped
        for (int i = 0; i < 4; i++) begin
            rreg(regs[i]);
            chk("reset value", usb_engine_pkg::REG_RESET, r);
        end
        $display("test reset done");
        wreg(E0, 8'h20);
        wreg(SC, 8'h18);
        // endpoint 0 in while stalled gets a stall handshake
        u_usb_host_model.xfer(T_IN, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        chk("ep0 stall in", {5'h00, usb_engine_pkg::HS_STALL, 1'b1}, ev);
        u_usb_host_model.xfer(usb_engine_pkg::TOK_SETUP, 4'h0, 1'b1, 1'b0, 1'b0, 4'h8, 1'b0);
        chk("setup answer", 8'h19, {3'h0, ev[4:0]});
        rreg(E0);
        chk("ep0 stall", 8'h00, r & 8'h20);
        rreg(SC);
        chk("setup clears", 8'h00, r & 8'h18);
        u_usb_host_model.xfer(usb_engine_pkg::TOK_SETUP, 4'h0, 1'b1, 1'b1, 1'b0, 4'h3, 1'b0);
        chk("setup error", 8'h18, {3'h0, ev[4:0]});
        rreg(E0);
        chk("rx error", 8'h10, r & 8'h10);
        // corner: a clean status stage with automatic status set
        wreg(SC, 8'h08);
        e = exp_out(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
        u_usb_host_model.xfer(T_OUT, 4'h0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0);
        chk("status out", e, {3'h0, ev[4:0]});
        $display("test setup done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            x = seed;
            wreg(E0, {2'b00, x[0], 5'h00});
            wreg(SC, {3'b000, x[2], x[1], 3'b000});
            seed = lfsr(seed);
            len = seed[7] ? 4'h0 : (seed[3:0] > 4'h9 ? 4'h9 : seed[3:0]);
            e = exp_out(x[0], x[1], x[2], seed[4] & seed[5], seed[6], len);
            u_usb_host_model.xfer(T_OUT, 4'h0, 1'b1, seed[4] & seed[5], seed[6], len, 1'b0);
            chk("out answer", e, {3'h0, ev[4:0]});
            rreg(SC);
            chk("out enable after", {3'h0, x[2] && !(e[0] && e[3]), 4'h0}, r & 8'h10);
        end
        $display("test out done");
        wreg(E1, 8'h85);
        u_usb_host_model.xfer(T_IN, 4'h1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        chk("ep1 disabled", 8'h00, ev);
        wreg(E1, 8'h30);
        u_usb_host_model.xfer(T_IN, 4'h1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        chk("ep1 stall in", {5'h00, usb_engine_pkg::HS_STALL, 1'b1}, ev);
        u_usb_host_model.xfer(T_OUT, 4'h1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
        chk("ep1 stall out", {5'h00, usb_engine_pkg::HS_STALL, 1'b1}, ev);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            len = seed[3] ? 4'h8 : {1'b0, seed[2:0]};
            wreg(E1, {4'b0001, len});
            wreg(E1, {1'b1, i[0], 2'b01, len});
            u_usb_host_model.xfer(T_IN, 4'h1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
            chk("ep1 in data", {3'b011, i[0], len}, {1'b0, ev[6], inf});
            chk("ep1 ack int", 8'h60, ev & 8'h7F);
            rreg(E1);
            chk("ep1 disarm", {1'b0, i[0], 2'b01, len}, r);
        end
        u_usb_host_model.xfer(T_IN, 4'h1, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        chk("ep1 unarmed", {5'h00, usb_engine_pkg::HS_NAK, 1'b1},
            {1'b0, ev[6], 3'h0, ev[2:0]});
        $display("test endpoint 1 done");
        wreg(SC, 8'h00);
        rreg(SC);
        chk("activity idle", 8'h00, r & 8'h01);
        u_usb_host_model.line(1'b1, 1'b0, 2);
        repeat (4) @(posedge clk);
        rreg(SC);
        chk("activity set", 8'h01, r & 8'h01);
        wreg(SC, 8'h01);
        rreg(SC);
        chk("activity kept", 8'h01, r & 8'h01);
        wreg(SC, 8'h00);
        rreg(SC);
        chk("activity cleared", 8'h00, r & 8'h01);
        wreg(SC, 8'h04);
        rreg(SC);
        chk("drive j", 8'h06, {r[5:2], drive_j, drive_k});
        wreg(SC, 8'h02);
        rreg(SC);
        chk("drive k", 8'h01, {r[5:2], drive_j, drive_k});
        wreg(SC, 8'h00);
        $display("test line done");
        // reset again with registers loaded
        wreg(E0, 8'h20);
        wreg(E1, 8'h5A);
        wreg(SC, 8'h18);
        @(posedge clk) #1;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rreg(regs[i]);
            chk("reset again", usb_engine_pkg::REG_RESET, r);
        end
        $display("test midrun reset done");
        summarize();
    end
endmodule // usb_endpoint_engine_control_tb
`default_nettype wire
